// file: include/evt_consts.vh
/*
 * Constants of the dual channel event timer: register byte offsets, field
 * positions, reset values and the interrupt vector number.
 * Assumes inclusion by bare name from design files compiled with include/.
 */
`ifndef EVT_CONSTS_VH
`define EVT_CONSTS_VH

`define EVT_OFS_CONFIG       12'h000
`define EVT_OFS_COUNT        12'h004
`define EVT_OFS_DIVIDER      12'h008
`define EVT_OFS_CONTROL      12'h00C
`define EVT_OFS_STATUS       12'h010
`define EVT_OFS_MASK         12'h014
`define EVT_OFS_CH0_A        12'h018
`define EVT_OFS_CH0_B        12'h01C
`define EVT_OFS_CH0_AA       12'h020
`define EVT_OFS_CH1_A        12'h024
`define EVT_OFS_CH1_B        12'h028
`define EVT_OFS_CH1_AA       12'h02C
`define EVT_OFS_GP_DIR       12'h030
`define EVT_OFS_GP_DATA      12'h034

`define EVT_CFG_START_POL    0
`define EVT_CFG_END_POL      1
`define EVT_CFG_DONE_ON_END  2
`define EVT_CFG_FREE_RUN     3
`define EVT_CFG_CH_STRIDE    4

`define EVT_RST_CONFIG       8'h00
`define EVT_RST_DIVIDER      16'h0001
`define EVT_RST_CONTROL      2'h0
`define EVT_RST_MASK         2'h3

`define EVT_IRQ_VECTOR       16'h0044

`endif

// file: verilog/evt_timer.v
/*
 * Dual channel event timer with AHB-Lite register slave.
 * Assumes a single clock hclk, asynchronous active-low reset hresetn,
 * and that the capture pins are asynchronous to hclk.
 */
// Design decisions made here: the AHB-Lite interface to the registers and the register addresses.
`default_nettype none
`include "evt_consts.vh"

// Overview of operation
// - A free-running 16-bit counter is readable through a read-only register.
// - Counter advances at clock divided by divider register, shared by channels.
// - Config bits 0 and 4 pick start edge: set rising, clear falling.
// - A sequence begins on the configured start edge of the channel pin.
// - Three capture registers latch first start, first end, second start.
// - Capture begins only after software sets the channel control bit.
// - Pins driven as outputs feed their written data into capture logic.
// - Config bits 2 and 6: set completes on end, clear on second start.
// - Completion on either channel raises one shared interrupt.
// - Reading the status register clears every bit not set by a completion in that same cycle.
// - Config bits 3 and 7: set free-running, clear single-shot.
// - Single-shot stops after completion until the control bit is set again.
// - Free-running keeps its control bit set and carries on capturing.
// - The interrupt uses vector 0x0044, below encoder, above first pin interrupt.
module evt_timer #(
    parameter CNT_W = 16,
    parameter DIV_W = 16
) (
    input  wire        hclk,
    input  wire        hresetn,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output wire        hreadyout,
    output wire        hresp,
    input  wire        capture_input_0,
    input  wire        capture_input_1,
    output wire        gp_pin_ten_out,
    output wire        gp_pin_ten_oe,
    output wire        gp_pin_eleven_out,
    output wire        gp_pin_eleven_oe,
    output wire        event_timer_irq,
    output wire [15:0] event_timer_vector
);
    localparam ST_IDLE = 3'b001;
    localparam ST_WAIT_B = 3'b010;
    localparam ST_WAIT_AA = 3'b100;

    reg  [7:0]       event_timer_config;
    reg  [CNT_W-1:0] event_timer_count;
    reg  [DIV_W-1:0] timebase_divider;
    reg  [DIV_W-1:0] div_cnt;
    reg  [1:0]       capture_control;
    reg  [1:0]       capture_status;
    reg  [1:0]       irq_mask;
    reg  [1:0]       gp_direction;
    reg  [1:0]       gp_output_data;
    wire [CNT_W-1:0] cap_a  [0:1];
    wire [CNT_W-1:0] cap_b  [0:1];
    wire [CNT_W-1:0] cap_aa [0:1];
    wire [2:0]       state  [0:1];
    reg  [1:0]       sync1, sync2, sync3, prev;
    wire [1:0]       done;
    reg              wr_pend;
    reg              rd_pend;
    reg  [11:0]      ap_addr;
    wire [1:0]       pin_in;
    wire [1:0]       ev_rise;
    wire [1:0]       ev_fall;
    wire             ap_take;
    wire [11:0]      rd_addr;

    // Picks one field of a channel from the configuration byte.
    function cfg_bit;
        input [7:0]   cfg;
        input integer ch;
        input integer fld;
        begin
            cfg_bit = cfg[ch*`EVT_CFG_CH_STRIDE + fld];
        end
    endfunction

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign event_timer_vector = `EVT_IRQ_VECTOR;
    assign gp_pin_ten_out    = gp_output_data[0];
    assign gp_pin_ten_oe     = gp_direction[0];
    assign gp_pin_eleven_out = gp_output_data[1];
    assign gp_pin_eleven_oe  = gp_direction[1];
    assign event_timer_irq = |(capture_status & irq_mask);

    // Output data loops back into capture.
    assign pin_in = {gp_direction[1] ? gp_output_data[1] : capture_input_1,
                     gp_direction[0] ? gp_output_data[0] : capture_input_0};

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1 <= 2'h0;
            sync2 <= 2'h0;
            sync3 <= 2'h0;
            prev  <= 2'h0;
        end else begin
            sync1 <= pin_in;
            sync2 <= sync1;
            sync3 <= sync2;
            if (sync2 == sync3) begin
                prev <= sync3;
            end
        end
    end
    assign ev_rise = (sync2 == sync3) ? (sync3 & ~prev) : 2'h0;
    assign ev_fall = (sync2 == sync3) ? (~sync3 & prev) : 2'h0;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_cnt           <= {DIV_W{1'b0}};
            event_timer_count <= {CNT_W{1'b0}};
        end else if (div_cnt + 1'b1 >= timebase_divider) begin
            div_cnt           <= {DIV_W{1'b0}};
            event_timer_count <= event_timer_count + 1'b1;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    assign ap_take = hsel && hready && htrans[1];
    assign rd_addr = ap_addr;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            ap_addr <= 12'h000;
        end else begin
            wr_pend <= ap_take && hwrite;
            rd_pend <= ap_take && !hwrite;
            if (ap_take) begin
                ap_addr <= {haddr[11:2], 2'b00};
            end
        end
    end

    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1) begin : g_ch
            wire             start_ev;
            wire             end_ev;
            wire             free_run;
            wire             done_on_end;
            reg  [2:0]       st;
            reg  [CNT_W-1:0] ca;
            reg  [CNT_W-1:0] cb;
            reg  [CNT_W-1:0] caa;
            reg              dn;
            assign start_ev = cfg_bit(event_timer_config, c, `EVT_CFG_START_POL)
                              ? ev_rise[c] : ev_fall[c];
            assign end_ev = cfg_bit(event_timer_config, c, `EVT_CFG_END_POL)
                            ? ev_rise[c] : ev_fall[c];
            assign free_run    = cfg_bit(event_timer_config, c, `EVT_CFG_FREE_RUN);
            assign done_on_end = cfg_bit(event_timer_config, c, `EVT_CFG_DONE_ON_END);
            assign state[c]    = st;
            assign cap_a[c]    = ca;
            assign cap_b[c]    = cb;
            assign cap_aa[c]   = caa;
            assign done[c]     = dn;

            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    st  <= ST_IDLE;
                    ca  <= {CNT_W{1'b0}};
                    cb  <= {CNT_W{1'b0}};
                    caa <= {CNT_W{1'b0}};
                    dn  <= 1'b0;
                end else begin
                    dn <= 1'b0;
                    case (st)
                        ST_IDLE: begin
                            // Armed by control; start edge begins.
                            if (capture_control[c] && start_ev) begin
                                ca <= event_timer_count;
                                st <= ST_WAIT_B;
                            end
                        end
                        ST_WAIT_B: begin
                            if (end_ev) begin
                                cb <= event_timer_count;
                                if (done_on_end) begin
                                    dn <= 1'b1;
                                    st <= ST_IDLE;
                                end else begin
                                    st <= ST_WAIT_AA;
                                end
                            end
                        end
                        ST_WAIT_AA: begin
                            if (start_ev) begin
                                caa <= event_timer_count;
                                dn  <= 1'b1;
                                st  <= ST_IDLE;
                            end
                        end
                        default: st <= ST_IDLE;
                    endcase
                    if (!capture_control[c]) begin
                        st <= ST_IDLE;
                    end
                end
            end
        end
    endgenerate

    // Register writes, control bits and sticky status.
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            event_timer_config <= `EVT_RST_CONFIG;
            timebase_divider   <= `EVT_RST_DIVIDER;
            capture_control    <= `EVT_RST_CONTROL;
            irq_mask           <= `EVT_RST_MASK;
            gp_direction       <= 2'h0;
            gp_output_data     <= 2'h0;
            capture_status     <= 2'h0;
        end else begin
            if (wr_pend) begin
                case (ap_addr)
                    `EVT_OFS_CONFIG:  event_timer_config <= hwdata[7:0];
                    `EVT_OFS_DIVIDER: timebase_divider   <= hwdata[DIV_W-1:0];
                    `EVT_OFS_CONTROL: capture_control    <= hwdata[1:0];
                    `EVT_OFS_MASK:    irq_mask           <= hwdata[1:0];
                    `EVT_OFS_GP_DIR:  gp_direction       <= hwdata[1:0];
                    `EVT_OFS_GP_DATA: gp_output_data     <= hwdata[1:0];
                    default: ;
                endcase
            end
            if (done[0] && !cfg_bit(event_timer_config, 0, `EVT_CFG_FREE_RUN)) begin
                capture_control[0] <= 1'b0;
            end
            if (done[1] && !cfg_bit(event_timer_config, 1, `EVT_CFG_FREE_RUN)) begin
                capture_control[1] <= 1'b0;
            end
            // Read clears; completion sets, winning over the clear.
            capture_status <= ((rd_pend && ap_addr == `EVT_OFS_STATUS)
                               ? 2'h0 : capture_status) | done;
        end
    end

    always @* begin
        case (rd_addr)
            `EVT_OFS_CONFIG:  hrdata = {24'h000000, event_timer_config};
            `EVT_OFS_COUNT:   hrdata = {{(32-CNT_W){1'b0}}, event_timer_count};
            `EVT_OFS_DIVIDER: hrdata = {{(32-DIV_W){1'b0}}, timebase_divider};
            `EVT_OFS_CONTROL: hrdata = {30'h00000000, capture_control};
            `EVT_OFS_STATUS:  hrdata = {30'h00000000, capture_status};
            `EVT_OFS_MASK:    hrdata = {30'h00000000, irq_mask};
            `EVT_OFS_CH0_A:   hrdata = {{(32-CNT_W){1'b0}}, cap_a[0]};
            `EVT_OFS_CH0_B:   hrdata = {{(32-CNT_W){1'b0}}, cap_b[0]};
            `EVT_OFS_CH0_AA:  hrdata = {{(32-CNT_W){1'b0}}, cap_aa[0]};
            `EVT_OFS_CH1_A:   hrdata = {{(32-CNT_W){1'b0}}, cap_a[1]};
            `EVT_OFS_CH1_B:   hrdata = {{(32-CNT_W){1'b0}}, cap_b[1]};
            `EVT_OFS_CH1_AA:  hrdata = {{(32-CNT_W){1'b0}}, cap_aa[1]};
            `EVT_OFS_GP_DIR:  hrdata = {30'h00000000, gp_direction};
            `EVT_OFS_GP_DATA: hrdata = {30'h00000000, gp_output_data};
            default:          hrdata = 32'h00000000;
        endcase
    end
endmodule // evt_timer
`default_nettype wire

// file: bench/evt_pin_model.sv
/* Model of the two outside signals that reach the capture pins.
   Assumes levels from the bench and the timer's gp pin drive and enable. */
`default_nettype none
module evt_pin_model (
    input  wire logic       hclk,
    input  wire logic [1:0] lvl,
    input  wire logic [1:0] gp_out,
    input  wire logic [1:0] gp_oe,
    output wire logic [1:0] pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] ext = 2'h0;
    // The outside source answers one clock after the bench asks.
    always @(posedge hclk) ext <= lvl;
    // Each pin shows the timer's drive while enabled, else the outside level.
    assign pin = (gp_oe & gp_out) | (~gp_oe & ext);
endmodule // evt_pin_model
`default_nettype wire

// file: bench/evt_timer_assertions.sv
/* Port checker of the event timer.
   Assumes the bind below and a single clock hclk with reset hresetn. */
`default_nettype none
module evt_timer_assertions (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        capture_input_0,
    input wire logic        capture_input_1,
    input wire logic        gp_pin_ten_out,
    input wire logic        gp_pin_ten_oe,
    input wire logic        gp_pin_eleven_out,
    input wire logic        gp_pin_eleven_oe,
    input wire logic        event_timer_irq,
    input wire logic [15:0] event_timer_vector
);
    logic        dp;
    logic        wr;
    logic [11:0] a;
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Data phase tracking of the bus.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp <= 1'b0;
            wr <= 1'b0;
            a  <= 12'h000;
        end else if (hready) begin
            dp <= hsel & htrans[1];
            wr <= hwrite;
            a  <= haddr[11:0];
        end
    end
    vector_fixed_a: assert property (event_timer_vector == 16'h0044)
        else $error("vector value differs");
    dir_ten_a: assert property (dp && wr && a == 12'h030
        |=> gp_pin_ten_oe == $past(hwdata[0])) else $error("pin ten enable wrong");
    dir_eleven_a: assert property (dp && wr && a == 12'h030
        |=> gp_pin_eleven_oe == $past(hwdata[1])) else $error("pin eleven enable wrong");
    data_ten_a: assert property (dp && wr && a == 12'h034
        |=> gp_pin_ten_out == $past(hwdata[0])) else $error("pin ten drive wrong");
    data_eleven_a: assert property (dp && wr && a == 12'h034
        |=> gp_pin_eleven_out == $past(hwdata[1])) else $error("pin eleven drive wrong");
    bus_okay_a: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not okay");
    count_width_a: assert property (dp && !wr && a == 12'h004
        |-> hrdata[31:16] == 16'h0000) else $error("count wider than 16 bits");
    capture_width_a: assert property (dp && !wr && a >= 12'h018 && a <= 12'h02C
        |-> hrdata[31:16] == 16'h0000) else $error("capture wider than 16 bits");
    status_width_a: assert property (dp && !wr && a == 12'h010
        |-> hrdata[31:2] == 30'h0) else $error("status has extra bits");
    control_width_a: assert property (dp && !wr && a == 12'h00C
        |-> hrdata[31:2] == 30'h0) else $error("control has extra bits");
    irq_status_a: assert property (dp && !wr && a == 12'h010 && event_timer_irq
        |-> hrdata[1:0] != 2'h0) else $error("interrupt without status");
    cover property (dp && !wr && a == 12'h010 && event_timer_irq);
    cover property ($rose(event_timer_irq));
    cover property (dp && wr && a == 12'h034);
endmodule // evt_timer_assertions
bind evt_timer evt_timer_assertions u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .capture_input_0,
    .capture_input_1, .gp_pin_ten_out, .gp_pin_ten_oe, .gp_pin_eleven_out,
    .gp_pin_eleven_oe, .event_timer_irq, .event_timer_vector);
`default_nettype wire

// file: bench/testbench.sv
/* Self-checking bench of the event timer with a pin model.
   Assumes a zero wait state bus slave and a 125 MHz clock. */
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0;
    logic [31:0] haddr = 0, hwdata = 0, hrdata, r, c0;
    logic [1:0]  htrans = 0, lvl = 0, pin, mk;
    logic        hreadyout, t_oe, t_out, e_oe, e_out, irq;
    bit          gp, sp, ep, de, fr;
    int          errors = 0, total_checks = 0, cyc = 0, ch, t[$];
    logic [11:0] ra[6] = '{12'h000, 12'h008, 12'h00C, 12'h014, 12'h010, 12'h03C};
    logic [31:0] rv[6] = '{32'h0, 32'h1, 32'h0, 32'h3, 32'h0, 32'h0};
    evt_pin_model u_pins (.hclk, .lvl, .gp_out({e_out, t_out}), .gp_oe({e_oe, t_oe}), .pin);
    evt_timer u_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
        .hready(hreadyout), .hrdata, .hreadyout, .hresp(), .capture_input_0(pin[0]),
        .capture_input_1(pin[1]), .gp_pin_ten_out(t_out), .gp_pin_ten_oe(t_oe),
        .gp_pin_eleven_out(e_out), .gp_pin_eleven_oe(e_oe), .event_timer_irq(irq),
        .event_timer_vector());
    always #4 hclk = ~hclk;
    always @(posedge hclk) cyc <= cyc + 1;
    task automatic results();
        if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        hsel   <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr  <= {20'h0, a};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        r = hrdata;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(r, exp);
    endtask
    task automatic setp(input bit v);
        if (gp) bus(1'b1, 12'h034, {30'h0, v, v});
        else lvl[ch] <= v;
    endtask
    task automatic ev(input bit v);
        setp(!v);
        repeat (8) @(posedge hclk);
        setp(v);
        t.push_back(cyc);
        repeat (10 + $urandom % 30) @(posedge hclk);
    endtask
    initial begin
        void'($urandom(5));
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        bus(1'b1, 12'h03C, 32'hFFFF_FFFF);
        foreach (ra[k]) rd(ra[k], rv[k]);
        for (int d = 1; d <= 4; d += 3) begin
            bus(1'b1, 12'h008, d);
            bus(1'b0, 12'h004, 32'h0);
            c0 = r;
            repeat (38) @(posedge hclk);
            bus(1'b0, 12'h004, 32'h0);
            chk({16'h0, r[15:0] - c0[15:0]}, 40 / d);
        end
        bus(1'b1, 12'h008, 32'h1);
        for (int i = 0; i < 4; i++) begin
            ch = i % 2;
            gp = (i >= 2);
            {sp, ep, de, fr} = 4'($urandom);
            mk = (i == 0) ? 2'h3 : 2'($urandom);
            bus(1'b1, 12'h014, {30'h0, mk});
            bus(1'b1, 12'h000, 32'({fr, de, ep, sp}) << (4 * ch));
            bus(1'b1, 12'h030, 32'(gp) << ch);
            setp(!sp);
            repeat (8) @(posedge hclk);
            bus(1'b1, 12'h00C, 32'h1 << ch);
            t.delete();
            ev(sp);
            ev(ep);
            if (!de) ev(sp);
            chk(irq, mk[ch]);
            rd(12'h010, 32'h1 << ch);
            rd(12'h010, 32'h0);
            @(posedge hclk);
            chk(irq, 32'h0);
            bus(1'b0, 12'(24 + 12 * ch), 32'h0);
            c0 = r;
            bus(1'b0, 12'(28 + 12 * ch), 32'h0);
            chk({16'h0, r[15:0] - c0[15:0]}, (t[1] - t[0]) & 32'hFFFF);
            if (!de) begin
                bus(1'b0, 12'(32 + 12 * ch), 32'h0);
                chk({16'h0, r[15:0] - c0[15:0]}, (t[2] - t[0]) & 32'hFFFF);
            end
            rd(12'h00C, 32'(fr) << ch);
            if (!fr) begin
                ev(sp);
                ev(ep);
                rd(12'h010, 32'h0);
            end
            bus(1'b1, 12'h00C, 32'h0);
        end
        results();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        errors++;
        results();
    end
endmodule // testbench
`default_nettype wire
